// >>> logic/freq_pull_pkg.sv
// Constants shared by the oscillator I2C register interface.
// Function
// - Pull range bits 15 to 4 read as zero; writes to them are ignored.
// - Four-bit pull range code picks span from 6.25 up to 3200 ppm.
// - Pull range field loads a factory default, then is writable over the bus.
// - Slave only; works at serial clock rates up to 1 Mbit/s.
// - Data changes only while clock is low, one bit per low period.
// - Bus idle when both lines high; only master frames transactions.
// - Start is data falling with clock high; stop is data rising with clock high.
// - Repeated start is handled exactly like a fresh start.
// - Bytes are 8 bits, most significant bit first, any count.
// - Receiver pulls data low on ninth clock to acknowledge.
// - Acknowledge every received byte except a mismatched device address.
// - Master acknowledges final read byte; device then releases data.
// - On master not-acknowledge the device keeps sending the next data.
// - Seven-bit device address then direction bit, 1 read, 0 write.
// - First write byte after address is the 8-bit register address.
// - Register address advances after each access, wrapping 255 to 0.
// - Registers move as two bytes, most significant byte first.
// - Read without address uses current counter, zero after startup.
// - Frequency pull starts within 140 us after high control word write.
// - Output settles within 20 us of pull start.
// - Control word is 26 bits: low 16 at reg 0, high 10 at reg 1.
// - Register 1 bit 10 enables output driver, default off, software control only.
package freq_pull_pkg;
  localparam logic [7:0]  REG_FREQ_LOW      = 8'h00;
  localparam logic [7:0]  REG_FREQ_HIGH     = 8'h01;
  localparam logic [7:0]  REG_PULL_RANGE    = 8'h02;
  localparam int          FREQ_HIGH_LSB     = 0;
  localparam int          FREQ_HIGH_W       = 10;
  localparam int          OUT_EN_BIT        = 10;
  localparam int          PULL_RANGE_W      = 4;
  localparam logic [15:0] FREQ_LOW_RST      = 16'h0000;
  localparam logic [9:0]  FREQ_HIGH_RST     = 10'h000;
  localparam logic        OUT_EN_RST        = 1'b0;
  localparam logic [7:0]  REG_ADDR_RST      = 8'h00;
  localparam logic [6:0]  DEV_ADDR_DEFAULT  = 7'h62;
  // Factory pull range code; value is a plain default.
  localparam logic [3:0]  PULL_RANGE_DEFAULT = 4'h9;
  localparam int          SYS_CLK_HZ        = 20000000;
  localparam int          PULL_DELAY_NS     = 103000;
  localparam int          PULL_DELAY_MAX_NS = 140000;
  localparam int          SETTLE_NS         = 16500;
  localparam int          SETTLE_MAX_NS     = 20000;
  localparam int          CLK_PERIOD_NS     = 1000000000 / SYS_CLK_HZ;
  localparam int          PULL_DELAY_CYC    = PULL_DELAY_NS / CLK_PERIOD_NS;
  localparam int          SETTLE_CYC        = SETTLE_NS / CLK_PERIOD_NS;
endpackage

// >>> logic/freq_pull_slave.sv
// I2C slave register interface for the digitally pulled oscillator.
`timescale 1ns/1ps
`default_nettype none
module freq_pull_slave #(
  parameter logic [6:0] DEV_ADDR       = freq_pull_pkg::DEV_ADDR_DEFAULT,
  parameter int         PULL_DELAY_CYC = freq_pull_pkg::PULL_DELAY_CYC,
  parameter int         SETTLE_CYC     = freq_pull_pkg::SETTLE_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        scl_clk,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n,
  output logic [25:0]      freq_word,
  output logic [3:0]       pull_range,
  output logic             out_enable,
  output logic             pull_start,
  output logic             pull_busy
);

  // ***************************************************************
  // Elaboration checks
  // ***************************************************************
  if (PULL_DELAY_CYC < 1 || PULL_DELAY_CYC > 65535) begin : g_bad_delay
    $error("pull delay count out of range");
  end
  if (SETTLE_CYC < 1 || SETTLE_CYC > 65535) begin : g_bad_settle
    $error("settle count out of range");
  end

  // ***************************************************************
  // Link domain reset and start/stop detection
  // ***************************************************************
  // The system reset is carried into the bus clock domain by two flops.
  logic rst_l1_q;
  logic rst_l2_q;
  always_ff @(posedge scl_clk) begin
    rst_l1_q <= sys_rst;
    rst_l2_q <= rst_l1_q;
  end

  // Start and stop toggle flags are clocked by data edges while the
  // clock is high, so that framing is seen even without clock edges.
  // They are cleared by the bus domain reset, because a data edge may
  // never arrive while the bus sits idle.
  logic start_tgl_q;
  logic stop_tgl_q;
  always_ff @(negedge sda_i or posedge rst_l2_q) begin
    if (rst_l2_q) begin
      start_tgl_q <= 1'b0;
    end else if (scl_clk) begin
      start_tgl_q <= ~start_tgl_q;
    end
  end
  always_ff @(posedge sda_i or posedge rst_l2_q) begin
    if (rst_l2_q) begin
      stop_tgl_q <= 1'b0;
    end else if (scl_clk) begin
      stop_tgl_q <= ~stop_tgl_q;
    end
  end

  logic start_seen_q;
  logic stop_seen_q;
  always_ff @(posedge scl_clk) begin
    if (rst_l2_q) begin
      start_seen_q <= 1'b0;
      stop_seen_q  <= 1'b0;
    end else begin
      start_seen_q <= start_tgl_q;
      stop_seen_q  <= stop_tgl_q;
    end
  end
  logic framed_start;
  logic framed_stop;
  assign framed_start = start_tgl_q ^ start_seen_q;
  assign framed_stop  = stop_tgl_q ^ stop_seen_q;

  // ***************************************************************
  // Bit engine on the bus clock
  // ***************************************************************
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_AACK  = 3'b011,
    ST_RXB   = 3'b010,
    ST_RACK  = 3'b110,
    ST_TXB   = 3'b111,
    ST_TACK  = 3'b101
  } bus_state_e;

  bus_state_e  st_q;
  logic [2:0]  bit_q;
  logic [7:0]  shift_q;
  logic        rd_q;
  logic        reg_ptr_set_q;
  logic        hi_byte_q;
  logic [7:0]  reg_addr_q;
  logic [7:0]  wr_hi_q;
  logic [15:0] tx_word_q;
  logic        drive_low_q;
  // Write request passed to the system domain as a toggle with data.
  logic        wr_tgl_q;
  logic [7:0]  wr_addr_q;
  logic [15:0] wr_data_q;
  logic [7:0]  rd_addr_l;

  // Read mirror of the system registers, crossed as a static level.
  logic [15:0] rd_mux;

  function automatic logic [7:0] addr_next(input logic [7:0] a);
    addr_next = a + 8'h01;
  endfunction

  // Sample data on the rising clock edge; it is stable while high.
  always_ff @(posedge scl_clk) begin
    // A stop is only seen at the next clock edge, which is also the
    // first bit after a following start; the start must win there.
    // The write toggle survives a stop, or the system side would see
    // a false write.
    if (rst_l2_q || (framed_stop && !framed_start)) begin
      st_q          <= ST_IDLE;
      bit_q         <= 3'h0;
      shift_q       <= 8'h00;
      rd_q          <= 1'b0;
      reg_ptr_set_q <= 1'b0;
      hi_byte_q     <= 1'b1;
      if (rst_l2_q) begin
        wr_hi_q    <= 8'h00;
        wr_tgl_q   <= 1'b0;
        wr_addr_q  <= freq_pull_pkg::REG_ADDR_RST;
        wr_data_q  <= 16'h0000;
        reg_addr_q <= freq_pull_pkg::REG_ADDR_RST;
      end
    end else if (framed_start) begin
      // First bit of the address byte is sampled on this edge.
      st_q          <= ST_ADDR;
      bit_q         <= 3'h1;
      shift_q       <= {7'h00, sda_i};
      reg_ptr_set_q <= 1'b0;
      hi_byte_q     <= 1'b1;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          st_q <= ST_IDLE;
        end
        ST_ADDR, ST_RXB: begin
          shift_q <= {shift_q[6:0], sda_i};
          bit_q   <= bit_q + 3'h1;
          if (bit_q == 3'h7) begin
            st_q <= (st_q == ST_ADDR) ? ST_AACK : ST_RACK;
          end
        end
        ST_AACK: begin
          bit_q <= 3'h0;
          if (shift_q[7:1] != DEV_ADDR) begin
            st_q <= ST_IDLE;
          end else begin
            rd_q <= shift_q[0];
            st_q <= shift_q[0] ? ST_TXB : ST_RXB;
          end
        end
        ST_RACK: begin
          bit_q <= 3'h0;
          st_q  <= ST_RXB;
          if (!reg_ptr_set_q) begin
            reg_addr_q    <= shift_q;
            reg_ptr_set_q <= 1'b1;
          end else if (hi_byte_q) begin
            wr_hi_q   <= shift_q;
            hi_byte_q <= 1'b0;
          end else begin
            wr_addr_q  <= reg_addr_q;
            wr_data_q  <= {wr_hi_q, shift_q};
            wr_tgl_q   <= ~wr_tgl_q;
            reg_addr_q <= addr_next(reg_addr_q);
            hi_byte_q  <= 1'b1;
          end
        end
        ST_TXB: begin
          bit_q <= bit_q + 3'h1;
          if (bit_q == 3'h7) begin
            st_q <= ST_TACK;
          end
        end
        ST_TACK: begin
          // Master acknowledge ends driving; a not-acknowledge keeps
          // the device sending the next byte.
          bit_q <= 3'h0;
          st_q  <= sda_i ? ST_TXB : ST_IDLE;
          if (!hi_byte_q) begin
            reg_addr_q <= addr_next(reg_addr_q);
          end
          hi_byte_q <= ~hi_byte_q;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // At the end of a word the pointer moves on in the same edge, so the
  // next word is looked up at the advanced address.
  assign rd_addr_l = (st_q == ST_TACK && !hi_byte_q) ? addr_next(reg_addr_q)
                                                     : reg_addr_q;

  // Word to send is latched at the start of each high byte.
  always_ff @(posedge scl_clk) begin
    if ((hi_byte_q && st_q == ST_AACK) || (!hi_byte_q && st_q == ST_TACK)) begin
      tx_word_q <= rd_mux;
    end
  end

  // Output drive changes on the falling edge, i.e. while clock is low.
  always_ff @(negedge scl_clk) begin
    if (rst_l2_q) begin
      drive_low_q <= 1'b0;
    end else begin
      unique case (st_q)
        ST_AACK: drive_low_q <= (shift_q[7:1] == DEV_ADDR);
        ST_RACK: drive_low_q <= 1'b1;
        ST_TXB:  drive_low_q <= hi_byte_q ? ~tx_word_q[4'd15 - {1'b0, bit_q}]
                                          : ~tx_word_q[4'd7 - {1'b0, bit_q}];
        default: drive_low_q <= 1'b0;
      endcase
    end
  end
  assign sda_o    = 1'b0;
  assign sda_oe_n = ~drive_low_q;

  // ***************************************************************
  // Crossing into the system domain
  // ***************************************************************
  logic wr_s1_q;
  logic wr_s2_q;
  logic wr_s3_q;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wr_s1_q <= 1'b0;
      wr_s2_q <= 1'b0;
      wr_s3_q <= 1'b0;
    end else begin
      wr_s1_q <= wr_tgl_q;
      wr_s2_q <= wr_s1_q;
      wr_s3_q <= wr_s2_q;
    end
  end
  logic wr_evt;
  assign wr_evt = wr_s2_q ^ wr_s3_q;

  // ***************************************************************
  // Registers
  // ***************************************************************
  logic [15:0] freq_low_q;
  logic [9:0]  freq_high_q;
  logic        out_en_q;
  logic [3:0]  range_q;
  logic        trig_q;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      freq_low_q  <= freq_pull_pkg::FREQ_LOW_RST;
      freq_high_q <= freq_pull_pkg::FREQ_HIGH_RST;
      out_en_q    <= freq_pull_pkg::OUT_EN_RST;
      range_q     <= freq_pull_pkg::PULL_RANGE_DEFAULT;
      trig_q      <= 1'b0;
    end else begin
      trig_q <= 1'b0;
      if (wr_evt) begin
        unique case (wr_addr_q)
          freq_pull_pkg::REG_FREQ_LOW:
            freq_low_q <= wr_data_q;
          freq_pull_pkg::REG_FREQ_HIGH: begin
            freq_high_q <= wr_data_q[freq_pull_pkg::FREQ_HIGH_W-1:0];
            out_en_q    <= wr_data_q[freq_pull_pkg::OUT_EN_BIT];
            trig_q      <= 1'b1;
          end
          freq_pull_pkg::REG_PULL_RANGE:
            range_q <= wr_data_q[freq_pull_pkg::PULL_RANGE_W-1:0];
          default: trig_q <= 1'b0;
        endcase
      end
    end
  end

  // Read data is static between writes, so the bus domain may sample it.
  always_comb begin
    unique case (rd_addr_l)
      freq_pull_pkg::REG_FREQ_LOW:   rd_mux = freq_low_q;
      freq_pull_pkg::REG_FREQ_HIGH:  rd_mux = {5'h00, out_en_q, freq_high_q};
      freq_pull_pkg::REG_PULL_RANGE: rd_mux = {12'h000, range_q};
      default:                       rd_mux = 16'h0000;
    endcase
  end

  // ***************************************************************
  // Pull delay and settle timing
  // ***************************************************************
  logic [15:0] delay_q;
  logic [15:0] settle_q;
  logic        delaying_q;
  logic        start_q;
  logic        busy_q;
  logic [25:0] word_q;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      delay_q    <= 16'h0000;
      settle_q   <= 16'h0000;
      delaying_q <= 1'b0;
      start_q    <= 1'b0;
      busy_q     <= 1'b0;
      word_q     <= {freq_pull_pkg::FREQ_HIGH_RST, freq_pull_pkg::FREQ_LOW_RST};
    end else begin
      start_q <= 1'b0;
      if (trig_q) begin
        delaying_q <= 1'b1;
        delay_q    <= 16'(PULL_DELAY_CYC - 1);
      end else if (delaying_q) begin
        if (delay_q == 16'h0000) begin
          delaying_q <= 1'b0;
          start_q    <= 1'b1;
          busy_q     <= 1'b1;
          word_q     <= {freq_high_q, freq_low_q};
          settle_q   <= 16'(SETTLE_CYC - 1);
        end else begin
          delay_q <= delay_q - 16'h0001;
        end
      end
      if (busy_q && !(delaying_q && !trig_q && delay_q == 16'h0000)) begin
        if (settle_q == 16'h0000) begin
          busy_q <= 1'b0;
        end else begin
          settle_q <= settle_q - 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    freq_word  <= word_q;
    pull_range <= range_q;
    out_enable <= out_en_q;
    pull_start <= start_q;
    pull_busy  <= busy_q;
  end

endmodule
`default_nettype wire

// >>> test/freq_pull_slave_assertions.sv
// Port checker for the oscillator I2C slave.
`timescale 1ns/1ps
`default_nettype none
module freq_pull_slave_assertions #(
  parameter logic [6:0] DEV_ADDR   = 7'h62,
  parameter int         SETTLE_CYC = 330
) (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        scl_clk,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe_n,
  input wire logic [25:0] freq_word,
  input wire logic        pull_start,
  input wire logic        pull_busy
);
  // ****************************
  // Bus tracking helpers
  // ****************************
  // A toggle marks each start, so the bit counter keeps one driver.
  logic       start_tog_q = 1'b0;
  logic       seen_tog_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] addr_sh_q;
  logic       oe_rise_q;
  logic [9:0] busy_len_q;
  logic       fresh;
  assign fresh = seen_tog_q != start_tog_q;
  always @(negedge sda_i) if (scl_clk) start_tog_q <= ~start_tog_q;
  always_ff @(posedge scl_clk) begin
    oe_rise_q <= sda_oe_n;
    addr_sh_q <= {addr_sh_q[6:0], sda_i};
    seen_tog_q <= start_tog_q;
    if (sys_rst) bit_cnt_q <= 4'hf;
    else if (fresh) bit_cnt_q <= 4'h1;
    else if (bit_cnt_q != 4'hf) bit_cnt_q <= bit_cnt_q + 4'h1;
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !pull_busy) busy_len_q <= 10'h000;
    else busy_len_q <= busy_len_q + 10'h001;
  end
  sequence addr_in;
    !fresh && bit_cnt_q == 4'h8;
  endsequence
  sequence settle_open;
    ##[0:2] pull_busy;
  endsequence
  a_addr_release: assert property (@(posedge scl_clk) disable iff (sys_rst)
    (fresh || bit_cnt_q < 4'h8) |-> sda_oe_n) else $error("address driven");
  a_addr_ack: assert property (@(posedge scl_clk) disable iff (sys_rst)
    addr_in ##0 addr_sh_q[7:1] == DEV_ADDR |-> !sda_oe_n) else $error("no ack");
  a_addr_nack: assert property (@(posedge scl_clk) disable iff (sys_rst)
    addr_in ##0 addr_sh_q[7:1] != DEV_ADDR |-> sda_oe_n) else $error("bad ack");
  a_sda_steady: assert property (@(negedge scl_clk) disable iff (sys_rst)
    oe_rise_q == sda_oe_n) else $error("data moved with clock high");
  a_drive_low: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !sda_o) else $error("data driven high");
  a_pull_pulse: assert property (@(posedge sys_clk) disable iff (sys_rst)
    pull_start |=> !pull_start) else $error("pull start too long");
  a_busy_follows: assert property (@(posedge sys_clk) disable iff (sys_rst)
    pull_start |-> settle_open) else $error("settle window missing");
  a_settle_len: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $fell(pull_busy) |-> busy_len_q == SETTLE_CYC) else $error("settle length");
  a_word_on_start: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !$stable(freq_word) |-> pull_start || $past(pull_start))
    else $error("word moved without pull");
endmodule
bind freq_pull_slave freq_pull_slave_assertions #(
  .DEV_ADDR  (DEV_ADDR),
  .SETTLE_CYC(SETTLE_CYC)
) chk (
  .sys_clk   (sys_clk),
  .sys_rst   (sys_rst),
  .scl_clk   (scl_clk),
  .sda_i     (sda_i),
  .sda_o     (sda_o),
  .sda_oe_n  (sda_oe_n),
  .freq_word (freq_word),
  .pull_start(pull_start),
  .pull_busy (pull_busy)
);
`default_nettype wire

// >>> test/i2c_master_model.sv
// Behavioural I2C bus master that makes the link clock.
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
  output logic      scl_clk,
  output logic      sda_low,
  input  wire logic sda_line
);
  // ****************************
  // Bit and byte tasks
  // ****************************
  // The clock idles high between frames; data is released to the pull-up.
  localparam realtime HALF = 7.5;
  initial begin
    scl_clk = 1'b1;
    sda_low = 1'b0;
  end
  task automatic idle(input int n);
    repeat (n) begin
      #HALF scl_clk = 1'b0;
      #HALF scl_clk = 1'b1;
    end
  endtask
  task automatic start();
    sda_low = 1'b0;
    #HALF scl_clk = 1'b1;
    #HALF sda_low = 1'b1;
    #HALF scl_clk = 1'b0;
  endtask
  task automatic stop();
    #(HALF/2) sda_low = 1'b1;
    #(HALF/2) scl_clk = 1'b1;
    #HALF sda_low = 1'b0;
    #HALF;
  endtask
  task automatic put_bit(input logic b);
    #(HALF/2) sda_low = ~b;
    #(HALF/2) scl_clk = 1'b1;
    #HALF scl_clk = 1'b0;
  endtask
  task automatic get_bit(output logic b);
    #(HALF/2) sda_low = 1'b0;
    #(HALF/2) scl_clk = 1'b1;
    b = sda_line;
    #HALF scl_clk = 1'b0;
  endtask
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) put_bit(b[i]);
    get_bit(ack);
  endtask
  task automatic get_byte(output logic [7:0] b, input logic nack);
    for (int i = 7; i >= 0; i--) get_bit(b[i]);
    put_bit(nack);
  endtask
endmodule
`default_nettype wire

// >>> test/freq_pull_slave_tb.sv
// Self-checking bench for the oscillator I2C slave.
`timescale 1ns/1ps
`default_nettype none
module freq_pull_slave_tb;
  localparam logic [6:0] DEV = freq_pull_pkg::DEV_ADDR_DEFAULT;
  localparam logic [3:0] RNG = freq_pull_pkg::PULL_RANGE_DEFAULT;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  wire logic   scl_clk;
  wire logic   sda_low;
  wire logic   sda_line;
  logic        sda_o;
  logic        sda_oe_n;
  logic [25:0] freq_word;
  logic [3:0]  pull_range;
  logic        out_enable;
  logic        pull_start;
  logic        pull_busy;
  logic [15:0] rd_q [4];
  int          err_total = 0;
  int          checks_done = 0;
  assign sda_line = !(sda_low || sda_oe_n === 1'b0);
  always #25 sys_clk = ~sys_clk;
  freq_pull_slave #(.PULL_DELAY_CYC(10), .SETTLE_CYC(5)) uut (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .scl_clk   (scl_clk),
    .sda_i     (sda_line),
    .sda_o     (sda_o),
    .sda_oe_n  (sda_oe_n),
    .freq_word (freq_word),
    .pull_range(pull_range),
    .out_enable(out_enable),
    .pull_start(pull_start),
    .pull_busy (pull_busy)
  );
  i2c_master_model mst (
    .scl_clk (scl_clk),
    .sda_low (sda_low),
    .sda_line(sda_line)
  );
  // ****************************
  // Shared tasks
  // ****************************
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic send(input logic [7:0] b, input logic lvl);
    logic ack;
    mst.put_byte(b, ack);
    check("ack", 32'(ack), 32'(lvl));
  endtask
  task automatic head(input logic [7:0] ra);
    mst.start();
    send({DEV, 1'b0}, 1'b0);
    send(ra, 1'b0);
  endtask
  // One or two words go to contiguous registers only.
  task automatic wr(input logic [7:0] ra, input logic [15:0] w0,
                    input logic [15:0] w1, input int n);
    head(ra);
    send(w0[15:8], 1'b0);
    send(w0[7:0], 1'b0);
    if (n > 1) begin
      send(w1[15:8], 1'b0);
      send(w1[7:0], 1'b0);
    end
    mst.stop();
  endtask
  task automatic rd(input logic [7:0] ra, input logic use_ra, input int n);
    if (use_ra) head(ra);
    mst.start();
    send({DEV, 1'b1}, 1'b0);
    for (int i = 0; i < n; i++) begin
      mst.get_byte(rd_q[i][15:8], 1'b1);
      mst.get_byte(rd_q[i][7:0], i + 1 != n);
    end
    mst.stop();
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ****************************
  // Scenarios
  // ****************************
  task automatic t_reset_read;
    check("range", 32'(pull_range), 32'(RNG));
    check("oe", 32'(out_enable), 32'h0);
    check("sda_o", 32'(sda_o), 32'h0);
    rd(8'h00, 1'b0, 3);
    check("r0", 32'(rd_q[0]), 32'h0);
    check("r1", 32'(rd_q[1]), 32'h0);
    check("r2", 32'(rd_q[2]), 32'(RNG));
  endtask
  task automatic t_bad_addr;
    mst.start();
    send({DEV ^ 7'h01, 1'b0}, 1'b1);
    mst.stop();
  endtask
  task automatic t_range;
    for (int i = 0; i < 16; i++) begin
      wr(8'h02, {12'hfff, 4'(i)}, 16'h0, 1);
      repeat (8) @(posedge sys_clk);
      check("range", 32'(pull_range), 32'(i));
    end
    rd(8'h02, 1'b1, 1);
    check("rrange", 32'(rd_q[0]), 32'h000f);
  endtask
  task automatic t_freq;
    int i;
    wr(8'h00, 16'h1234, 16'hffff, 2);
    for (i = 0; i < 60 && pull_start !== 1'b1; i++) @(negedge sys_clk);
    check("delay", 32'(i < 26), 32'h1);
    @(negedge sys_clk);
    check("word", 32'(freq_word), 32'h03ff1234);
    check("busy", 32'(pull_busy), 32'h1);
    repeat (4) @(negedge sys_clk);
    check("busy_end", 32'(pull_busy), 32'h0);
    check("oe", 32'(out_enable), 32'h1);
    rd(8'h01, 1'b1, 1);
    check("r1", 32'(rd_q[0]), 32'h07ff);
  endtask
  task automatic t_wrap;
    wr(8'hff, 16'habcd, 16'h5678, 2);
    repeat (8) @(posedge sys_clk);
    rd(8'hff, 1'b1, 2);
    check("rff", 32'(rd_q[0]), 32'h0);
    check("r0", 32'(rd_q[1]), 32'h5678);
    check("word", 32'(freq_word), 32'h03ff1234);
  endtask
  initial begin
    mst.idle(8);
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    mst.idle(4);
    @(negedge sys_clk);
    t_reset_read();
    t_bad_addr();
    t_range();
    t_freq();
    t_wrap();
    wrap_up();
  end
  initial begin
    #400000;
    err_total++;
    wrap_up();
  end
endmodule
`default_nettype wire
